// [flash_array_model.sv]
// behavioural flash array: timed step completion and the stored option word
module flash_array_model
	import flash_pe_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// commands and step time
	input  wire array_cmd_t  cmd_in,
	input  wire logic [7:0]  delay_in,
	// answers to the controller
	output logic             done_out,
	output logic [31:0]      stored_out,
	output logic             valid_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  cnt = 8'h0;
	logic [2:0]  boot = 3'h0;
	logic [31:0] word = 32'h0ff5cc7c;
	initial done_out = 1'b0;
	initial valid_out = 1'b0;
	// the word is only meaningful while valid, so it is scrambled otherwise
	assign stored_out = valid_out ? word : ~word;
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (rst_in) begin
			cnt <= 8'h0;
			boot <= 3'h0;
			valid_out <= 1'b0;
		end else begin
			if (boot != 3'h4) boot <= boot + 3'h1;
			valid_out <= (boot == 3'h4);
			if (cmd_in.erase_option) word <= 32'hffffffff;
			if (cmd_in.program_option) word <= cmd_in.option_data;
			if (|{cmd_in.erase_sector, cmd_in.erase_all, cmd_in.erase_option, cmd_in.program_word,
				cmd_in.program_option}) begin
				cnt <= delay_in;
			end else if (cnt == 8'h1) begin
				done_out <= 1'b1;
				cnt <= 8'h0;
			end else if (cnt != 8'h0) begin
				cnt <= cnt - 8'h1;
			end
		end
	end
endmodule

// [flash_pe_assertions.sv]
// port-level checks of the program/erase controller
module flash_pe_checker
	import flash_pe_pkg::*;
#(
	parameter int SECTORS = 12
) (
	// clock and reset
	input wire logic        CLK_SYS_IN,
	input wire logic        SYS_RST_IN,
	// register and flash write ports
	input wire reg_req_t    REG_REQ_IN,
	input wire logic [31:0] REG_RDATA_OUT,
	input wire mem_wr_t     MEM_WR_IN,
	// array side and decoded outputs
	input wire logic        ARRAY_DONE_IN,
	input wire array_cmd_t  ARRAY_CMD_OUT,
	input wire logic [1:0]  READ_PROTECT_LEVEL_OUT,
	input wire logic        BROWNOUT_OFF_OUT,
	input wire logic        FLASH_IRQ_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	// command pulses and the level expected from read-back protect code
	wire logic [4:0] pulses = {ARRAY_CMD_OUT.erase_sector, ARRAY_CMD_OUT.erase_all, ARRAY_CMD_OUT.erase_option,
		ARRAY_CMD_OUT.program_word, ARRAY_CMD_OUT.program_option};
	wire logic [7:0] prot_seen = REG_RDATA_OUT[15:8];
	wire logic [1:0] prot_exp = (prot_seen == PROT_LEVEL0) ? 2'h0 : ((prot_seen == PROT_LEVEL2) ? 2'h2 : 2'h1);
	// reads whose answer is judged one cycle later
	sequence s_key_read;
		REG_REQ_IN.rd && (REG_REQ_IN.addr == OFF_PROGRAM_UNLOCK_KEY || REG_REQ_IN.addr == OFF_OPTION_UNLOCK_KEY);
	endsequence
	sequence s_opt_read;
		REG_REQ_IN.rd && REG_REQ_IN.addr == OFF_OPTION_CONTROL;
	endsequence
	sequence s_stat_read;
		REG_REQ_IN.rd && REG_REQ_IN.addr == OFF_OPERATION_STATUS && !ARRAY_DONE_IN && !MEM_WR_IN.wr;
	endsequence
	a_key_read_zero: assert property (s_key_read |=> REG_RDATA_OUT == 32'h0)
		else $error("key register read back nonzero");
	a_prot_decode: assert property (s_opt_read |=> READ_PROTECT_LEVEL_OUT == prot_exp)
		else $error("read protect level decode wrong");
	a_bor_decode: assert property (s_opt_read |=> BROWNOUT_OFF_OUT == (REG_RDATA_OUT[3:2] == BOR_OFF))
		else $error("brownout off decode wrong");
	a_cmd_one_hot: assert property ($onehot0(pulses))
		else $error("two array commands at once");
	a_sector_range: assert property (ARRAY_CMD_OUT.erase_sector |-> ARRAY_CMD_OUT.sector <= LAST_SECTOR)
		else $error("erase of a sector beyond eleven");
	a_program_cause: assert property (ARRAY_CMD_OUT.program_word |-> $past(MEM_WR_IN.wr))
		else $error("program command without a flash write");
	a_erase_cause: assert property ((ARRAY_CMD_OUT.erase_sector || ARRAY_CMD_OUT.erase_all) |->
		$past(REG_REQ_IN.wr, 2) && $past(REG_REQ_IN.addr, 2) == OFF_OPERATION_CONTROL)
		else $error("erase not two cycles after a control write");
	a_option_cause: assert property (ARRAY_CMD_OUT.erase_option |->
		$past(REG_REQ_IN.wr, 2) && $past(REG_REQ_IN.addr, 2) == OFF_OPTION_CONTROL)
		else $error("option erase not two cycles after an option write");
	a_irq_flags: assert property (s_stat_read |=> !FLASH_IRQ_OUT || REG_RDATA_OUT[SR_OPE] || REG_RDATA_OUT[SR_DONE])
		else $error("interrupt without a flag");
	a_reset_quiet: assert property ($fell(SYS_RST_IN) |-> !FLASH_IRQ_OUT && pulses == 5'h0)
		else $error("interrupt or command right after reset");
endmodule

bind flash_program_erase_control flash_pe_checker #(.SECTORS(SECTORS)) u_checker (
	.CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .REG_REQ_IN(REG_REQ_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
	.MEM_WR_IN(MEM_WR_IN), .ARRAY_DONE_IN(ARRAY_DONE_IN), .ARRAY_CMD_OUT(ARRAY_CMD_OUT),
	.READ_PROTECT_LEVEL_OUT(READ_PROTECT_LEVEL_OUT), .BROWNOUT_OFF_OUT(BROWNOUT_OFF_OUT), .FLASH_IRQ_OUT(FLASH_IRQ_OUT));

// [flash_pe_pkg.sv]
// package: register map, field positions, keys and types of the program/erase controller
package flash_pe_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_PROGRAM_UNLOCK_KEY = 8'h04;
	localparam logic [7:0] OFF_OPTION_UNLOCK_KEY  = 8'h08;
	localparam logic [7:0] OFF_OPERATION_STATUS   = 8'h0c;
	localparam logic [7:0] OFF_OPERATION_CONTROL  = 8'h10;
	localparam logic [7:0] OFF_OPTION_CONTROL     = 8'h14;

	// unlock keys
	localparam logic [31:0] FIRST_UNLOCK_KEY  = 32'h45670123;
	localparam logic [31:0] SECOND_UNLOCK_KEY = 32'hcdef89ab;
	localparam logic [31:0] FIRST_OPTION_KEY  = 32'h08192a3b;
	localparam logic [31:0] SECOND_OPTION_KEY = 32'h4c5d6e7f;

	// reset values
	localparam logic [31:0] CONTROL_RESET = 32'h80000000;
	localparam logic [31:0] OPTION_RESET  = 32'h0fffaaed;

	// status bit positions
	localparam int SR_BUSY = 16;
	localparam int SR_SEQ  = 7;
	localparam int SR_PAR  = 6;
	localparam int SR_ALN  = 5;
	localparam int SR_WRP  = 4;
	localparam int SR_OPE  = 1;
	localparam int SR_DONE = 0;

	// control bit positions
	localparam int CR_LOCK   = 31;
	localparam int CR_ERR_EN = 25;
	localparam int CR_DONEIE = 24;
	localparam int CR_START  = 16;
	localparam int CR_SIZE   = 8;
	localparam int CR_SECTOR = 3;
	localparam int CR_ALL    = 2;
	localparam int CR_SECT   = 1;
	localparam int CR_PROG   = 0;

	// option control bit positions and writable mask
	localparam int OPT_WRP       = 16;
	localparam int OPT_READ_PROT = 8;
	localparam int OPT_BOR       = 2;
	localparam int OPT_START     = 1;
	localparam int OPT_LOCK      = 0;
	localparam logic [31:0] OPT_FIELD_MASK = 32'h0fffffec;

	// read protect and brown-out codes
	localparam logic [7:0] PROT_LEVEL0 = 8'haa;
	localparam logic [7:0] PROT_LEVEL2 = 8'hcc;
	localparam logic [1:0] BOR_OFF    = 2'h3;
	localparam logic [3:0] LAST_SECTOR = 4'hb;

	// program sizes
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_HALF = 2'h1,
		SIZE_WORD = 2'h2,
		SIZE_DBL  = 2'h3
	} program_size_field_t;

	// register bus request from the processor
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} reg_req_t;

	// processor write into the flash array
	typedef struct packed {
		logic        wr;
		logic [1:0]  size;
		logic [23:0] addr;
	} mem_wr_t;

	// command to the flash array
	typedef struct packed {
		logic        erase_sector;
		logic        erase_all;
		logic        erase_option;
		logic        program_word;
		logic        program_option;
		logic [3:0]  sector;
		logic [31:0] option_data;
	} array_cmd_t;

endpackage

// [flash_program_erase_control.sv]
// program/erase controller: keys, locks, status, control and option registers
module flash_program_erase_control
	import flash_pe_pkg::*;
#(
	parameter int SECTORS = 12
) (
	// clock and reset
	input  wire logic        CLK_SYS_IN,
	input  wire logic        SYS_RST_IN,
	// register port
	input  wire reg_req_t    REG_REQ_IN,
	output logic [31:0]      REG_RDATA_OUT,
	// processor writes into the flash array
	input  wire mem_wr_t     MEM_WR_IN,
	input  wire logic [3:0]  MEM_SECTOR_IN,
	// flash array side
	input  wire logic [31:0] STORED_OPTION_IN,
	input  wire logic        STORED_OPTION_VALID_IN,
	input  wire logic        ARRAY_DONE_IN,
	output array_cmd_t       ARRAY_CMD_OUT,
	// decoded options
	output logic [1:0]       READ_PROTECT_LEVEL_OUT,
	output logic             BROWNOUT_OFF_OUT,
	// interrupt
	output logic             FLASH_IRQ_OUT
);

	// only the twelve-sector layout is served
	if (SECTORS != 12) begin : g_bad_sectors
		$error("sector count must be 12");
	end

	typedef enum logic [5:0] {
		PH_LOAD   = 6'b000001,
		PH_IDLE   = 6'b000010,
		PH_ERASE  = 6'b000100,
		PH_PROG   = 6'b001000,
		PH_OERASE = 6'b010000,
		PH_OPROG  = 6'b100000
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [31:0] status;
		logic [31:0] control;
		logic [31:0] option;
		array_cmd_t  cmd;
		logic [31:0] rdata;
		logic        got_op;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic ctl_locked;
	logic opt_locked;
	logic ctl_key_wr;
	logic opt_key_wr;
	logic ctl_relock;
	logic opt_relock;
	logic ctl_wr;
	logic opt_wr;

	// bytes per program size code
	function automatic logic [3:0] size_bytes(input logic [1:0] code);
		case (code)
			SIZE_BYTE: size_bytes = 4'h1;
			SIZE_HALF: size_bytes = 4'h2;
			SIZE_WORD: size_bytes = 4'h4;
			default:   size_bytes = 4'h8;
		endcase
	endfunction

	// sector is protected when its unprotect bit is zero
	function automatic logic sector_protected(input logic [31:0] opt, input logic [3:0] sec);
		logic [11:0] wrp;
		wrp = opt[OPT_WRP +: 12];
		if (sec > LAST_SECTOR) begin
			sector_protected = 1'b1;
		end else begin
			sector_protected = ~wrp[sec];
		end
	endfunction

	// register write strobes
	assign ctl_key_wr = REG_REQ_IN.wr && REG_REQ_IN.addr == OFF_PROGRAM_UNLOCK_KEY;
	assign opt_key_wr = REG_REQ_IN.wr && REG_REQ_IN.addr == OFF_OPTION_UNLOCK_KEY;
	assign ctl_wr     = REG_REQ_IN.wr && REG_REQ_IN.addr == OFF_OPERATION_CONTROL;
	assign opt_wr     = REG_REQ_IN.wr && REG_REQ_IN.addr == OFF_OPTION_CONTROL;
	assign ctl_relock = ctl_wr && REG_REQ_IN.wdata[CR_LOCK];
	assign opt_relock = opt_wr && REG_REQ_IN.wdata[OPT_LOCK];

	unlock_tracker #(
		.FIRST_KEY  (FIRST_UNLOCK_KEY),
		.SECOND_KEY (SECOND_UNLOCK_KEY)
	) ctl_unlock (
		.clk_in     (CLK_SYS_IN),
		.rst_in     (SYS_RST_IN),
		.key_wr_in  (ctl_key_wr),
		.key_in     (REG_REQ_IN.wdata),
		.relock_in  (ctl_relock),
		.locked_out (ctl_locked)
	);

	unlock_tracker #(
		.FIRST_KEY  (FIRST_OPTION_KEY),
		.SECOND_KEY (SECOND_OPTION_KEY)
	) opt_unlock (
		.clk_in     (CLK_SYS_IN),
		.rst_in     (SYS_RST_IN),
		.key_wr_in  (opt_key_wr),
		.key_in     (REG_REQ_IN.wdata),
		.relock_in  (opt_relock),
		.locked_out (opt_locked)
	);

	// next-state logic for registers and the operation sequencer
	always_comb begin
		logic        busy;
		logic        seq_err;
		logic        par_err;
		logic        aln_err;
		logic        wrp_err;
		logic        any_err;
		logic        finish;
		logic [4:0]  end_byte;
		logic [31:0] clr;
		state_next = state_reg;
		busy       = state_reg.phase != PH_IDLE && state_reg.phase != PH_LOAD;
		seq_err    = 1'b0;
		par_err    = 1'b0;
		aln_err    = 1'b0;
		wrp_err    = 1'b0;
		any_err    = 1'b0;
		finish     = 1'b0;
		clr        = 32'h0;
		// end address of the write within a 16-byte row
		end_byte   = {1'b0, MEM_WR_IN.addr[3:0]} + {1'b0, size_bytes(MEM_WR_IN.size)};
		state_next.cmd.erase_sector   = 1'b0;
		state_next.cmd.erase_all      = 1'b0;
		state_next.cmd.erase_option   = 1'b0;
		state_next.cmd.program_word   = 1'b0;
		state_next.cmd.program_option = 1'b0;

		// option fields loaded once the stored bytes are valid
		if (state_reg.phase == PH_LOAD && STORED_OPTION_VALID_IN) begin
			state_next.option = (STORED_OPTION_IN & OPT_FIELD_MASK) | 32'h00000001;
			state_next.phase  = PH_IDLE;
		end

		// status write one to clear
		if (REG_REQ_IN.wr && REG_REQ_IN.addr == OFF_OPERATION_STATUS) begin
			clr = REG_REQ_IN.wdata & 32'h000000f3;
		end

		// control writes only while unlocked and idle
		if (ctl_wr && !ctl_locked && !busy) begin
			state_next.control[CR_ERR_EN] = REG_REQ_IN.wdata[CR_ERR_EN];
			state_next.control[CR_DONEIE] = REG_REQ_IN.wdata[CR_DONEIE];
			state_next.control[CR_SIZE +: 2] = REG_REQ_IN.wdata[CR_SIZE +: 2];
			state_next.control[CR_SECTOR +: 4] = REG_REQ_IN.wdata[CR_SECTOR +: 4];
			state_next.control[2:0] = REG_REQ_IN.wdata[2:0];
			if (REG_REQ_IN.wdata[CR_START]) begin
				state_next.control[CR_START] = 1'b1;
			end
		end
		state_next.control[CR_LOCK] = ctl_locked;

		// option writes only while unlocked and idle
		if (opt_wr && !opt_locked && !busy) begin
			// sector unprotect, read protect, user, brownout fields
			state_next.option = (REG_REQ_IN.wdata & OPT_FIELD_MASK) | (state_reg.option & ~OPT_FIELD_MASK);
			if (REG_REQ_IN.wdata[OPT_START]) begin
				state_next.option[OPT_START] = 1'b1;
			end
		end
		state_next.option[OPT_LOCK] = opt_locked;

		case (state_reg.phase)
			PH_IDLE: begin
				if (state_reg.control[CR_START]) begin
					if (state_reg.control[CR_ALL]) begin
						wrp_err = |(~state_reg.option[OPT_WRP +: 12]);
					end else if (state_reg.control[CR_SECT]) begin
						wrp_err = sector_protected(state_reg.option, state_reg.control[CR_SECTOR +: 4]);
					end else begin
						seq_err = 1'b1;
					end
					if (wrp_err || seq_err) begin
						state_next.control[CR_START] = 1'b0;
					end else begin
						state_next.cmd.erase_all    = state_reg.control[CR_ALL];
						state_next.cmd.erase_sector = ~state_reg.control[CR_ALL];
						state_next.cmd.sector       = state_reg.control[CR_SECTOR +: 4];
						state_next.phase            = PH_ERASE;
					end
				end else if (state_reg.option[OPT_START]) begin
					state_next.cmd.erase_option = 1'b1;
					state_next.phase            = PH_OERASE;
				end else if (MEM_WR_IN.wr) begin
					seq_err = ctl_locked || !state_reg.control[CR_PROG] ||
						state_reg.control[CR_ALL] || state_reg.control[CR_SECT];
					par_err = MEM_WR_IN.size != state_reg.control[CR_SIZE +: 2];
					aln_err = end_byte > 5'h10;
					wrp_err = sector_protected(state_reg.option, MEM_SECTOR_IN);
					if (!(seq_err || par_err || aln_err || wrp_err)) begin
						state_next.cmd.program_word = 1'b1;
						state_next.cmd.sector       = MEM_SECTOR_IN;
						state_next.phase            = PH_PROG;
					end
				end
			end
			PH_ERASE, PH_PROG: begin
				if (ARRAY_DONE_IN) begin
					finish                       = 1'b1;
					state_next.control[CR_START] = 1'b0;
					state_next.phase             = PH_IDLE;
				end
			end
			// erase configuration sector then program options
			PH_OERASE: begin
				if (ARRAY_DONE_IN) begin
					state_next.cmd.program_option = 1'b1;
					state_next.cmd.option_data    = state_reg.option & OPT_FIELD_MASK;
					state_next.phase              = PH_OPROG;
				end
			end
			PH_OPROG: begin
				if (ARRAY_DONE_IN) begin
					finish                        = 1'b1;
					state_next.option[OPT_START]  = 1'b0;
					state_next.phase              = PH_IDLE;
				end
			end
			PH_LOAD: begin
			end
			default: begin
				state_next.phase = PH_IDLE;
			end
		endcase

		// error flags: set wins over clear
		any_err = seq_err || par_err || aln_err || wrp_err;
		state_next.status[SR_SEQ] = seq_err || (state_reg.status[SR_SEQ] && !clr[SR_SEQ]);
		state_next.status[SR_PAR] = par_err || (state_reg.status[SR_PAR] && !clr[SR_PAR]);
		state_next.status[SR_ALN] = aln_err || (state_reg.status[SR_ALN] && !clr[SR_ALN]);
		state_next.status[SR_WRP] = wrp_err || (state_reg.status[SR_WRP] && !clr[SR_WRP]);
		// operation error gated by error enable
		state_next.status[SR_OPE] = (any_err && state_reg.control[CR_ERR_EN]) ||
			(state_reg.status[SR_OPE] && !clr[SR_OPE]);
		// done flag gated by done enable
		state_next.status[SR_DONE] = (finish && state_reg.control[CR_DONEIE]) ||
			(state_reg.status[SR_DONE] && !clr[SR_DONE]);
		state_next.status[SR_BUSY] = state_next.phase != PH_IDLE && state_next.phase != PH_LOAD;

		// registered read data
		state_next.rdata = 32'h0;
		if (REG_REQ_IN.rd) begin
			case (REG_REQ_IN.addr)
				OFF_OPERATION_STATUS:  state_next.rdata = state_reg.status;
				OFF_OPERATION_CONTROL: state_next.rdata = {ctl_locked, state_reg.control[30:0]};
				OFF_OPTION_CONTROL:    state_next.rdata = {state_reg.option[31:1], opt_locked};
				default:               state_next.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			state_reg         <= '0;
			state_reg.phase   <= PH_LOAD;
			state_reg.control <= CONTROL_RESET;
			state_reg.option  <= OPTION_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs
	assign REG_RDATA_OUT = state_reg.rdata;
	assign ARRAY_CMD_OUT = state_reg.cmd;

	always_comb begin
		case (state_reg.option[OPT_READ_PROT +: 8])
			PROT_LEVEL0: READ_PROTECT_LEVEL_OUT = 2'h0;
			PROT_LEVEL2: READ_PROTECT_LEVEL_OUT = 2'h2;
			default:    READ_PROTECT_LEVEL_OUT = 2'h1;
		endcase
	end

	assign BROWNOUT_OFF_OUT = state_reg.option[OPT_BOR +: 2] == BOR_OFF;

	// enabled error or done raises interrupt
	assign FLASH_IRQ_OUT = (state_reg.status[SR_OPE] && state_reg.control[CR_ERR_EN]) ||
		(state_reg.status[SR_DONE] && state_reg.control[CR_DONEIE]);

endmodule

// [tb_top.sv]
// self-checking bench: register map, locks, operations and option update
module tb_top
	import flash_pe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// one operation per row: control value, flash write, expected status
	typedef struct packed {
		logic [31:0] ctrl;
		logic        mw;
		logic [1:0]  size;
		logic [23:0] addr;
		logic [3:0]  sect;
		logic [7:0]  exp;
	} op_row_t;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] exp;
	} rd_row_t;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	reg_req_t    req = '0;
	mem_wr_t     mem = '0;
	logic [3:0]  msect = 4'h0;
	logic [7:0]  delay = 8'h3;
	logic [31:0] rdata;
	logic [31:0] stored;
	logic        svalid;
	logic        adone;
	array_cmd_t  cmd;
	logic [1:0]  prot_lvl;
	logic        boroff;
	logic        irq;
	logic [31:0] seen;
	logic [3:0]  last_sector = 4'hf;
	int          n_errors = 0;
	int          tests_run = 0;
	rd_row_t     rd_rows [7] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0}, '{8'h0c, 32'h0},
		'{8'h10, CONTROL_RESET}, '{8'h14, 32'h0ff5cc6d}, '{8'h18, 32'h0}};
	op_row_t     ops [14] = '{
		'{32'h03010212, 1'b0, 2'h0, 24'h0, 4'h0, 8'h01}, '{32'h0301021a, 1'b0, 2'h0, 24'h0, 4'h0, 8'h12},
		'{32'h03010204, 1'b0, 2'h0, 24'h0, 4'h0, 8'h12}, '{32'h03010200, 1'b0, 2'h0, 24'h0, 4'h0, 8'h82},
		'{32'h03000201, 1'b1, 2'h2, 24'h10, 4'h0, 8'h01}, '{32'h03000201, 1'b1, 2'h0, 24'h10, 4'h0, 8'h42},
		'{32'h03000201, 1'b1, 2'h2, 24'h0e, 4'h0, 8'h22}, '{32'h03000200, 1'b1, 2'h2, 24'h10, 4'h0, 8'h82},
		'{32'h03000201, 1'b1, 2'h2, 24'h10, 4'h1, 8'h12}, '{32'h03000301, 1'b1, 2'h3, 24'h18, 4'h0, 8'h01},
		'{32'h03000101, 1'b1, 2'h1, 24'h02, 4'h0, 8'h01}, '{32'h03000001, 1'b1, 2'h0, 24'h05, 4'h0, 8'h01},
		'{32'h00000201, 1'b1, 2'h2, 24'h20, 4'h0, 8'h00}, '{32'h00000200, 1'b1, 2'h2, 24'h20, 4'h0, 8'h80}};

	flash_program_erase_control #(.SECTORS(12)) dut (
		.CLK_SYS_IN(clk_sys), .SYS_RST_IN(sys_rst), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
		.MEM_WR_IN(mem), .MEM_SECTOR_IN(msect), .STORED_OPTION_IN(stored), .STORED_OPTION_VALID_IN(svalid),
		.ARRAY_DONE_IN(adone), .ARRAY_CMD_OUT(cmd), .READ_PROTECT_LEVEL_OUT(prot_lvl), .BROWNOUT_OFF_OUT(boroff),
		.FLASH_IRQ_OUT(irq));
	flash_array_model array_model (.clk_in(clk_sys), .rst_in(sys_rst), .cmd_in(cmd), .delay_in(delay),
		.done_out(adone), .stored_out(stored), .valid_out(svalid));

	// 125 MHz clock and capture of the erased sector
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (cmd.erase_sector) last_sector <= cmd.sector;
	end

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one register write or read, request held for exactly one edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk_sys);
		req <= '0;
		#1 d = rdata;
	endtask
	task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] e);
		rd(a, seen);
		check(what, seen, e);
	endtask
	// poll the busy flag with a bounded count
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge clk_sys);
		do begin
			rd(OFF_OPERATION_STATUS, seen);
			n++;
		end while (seen[SR_BUSY] !== 1'b0 && n < 200);
		if (seen[SR_BUSY] !== 1'b0) begin
			n_errors++;
			complete_run();
		end
	endtask
	task automatic release_reset();
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		release_reset();
		foreach (rd_rows[i]) begin
			chk_rd("reset map", rd_rows[i].addr, rd_rows[i].exp);
		end
		check("protect level", 32'(prot_lvl), 32'h2);
		check("bor off", 32'(boroff), 32'h1);
		wr(OFF_OPERATION_CONTROL, 32'h03000000);
		chk_rd("locked ctrl", OFF_OPERATION_CONTROL, CONTROL_RESET);
		wr(OFF_PROGRAM_UNLOCK_KEY, FIRST_UNLOCK_KEY);
		wr(OFF_PROGRAM_UNLOCK_KEY, SECOND_UNLOCK_KEY);
		chk_rd("unlocked ctrl", OFF_OPERATION_CONTROL, 32'h0);
		$display("test reset and unlock done");
		// operations with prompt and slow array answers
		foreach (ops[i]) begin
			delay <= 8'(3 + 5 * i);
			wr(OFF_OPERATION_CONTROL, ops[i].ctrl);
			if (ops[i].mw) begin
				@(posedge clk_sys);
				mem <= '{1'b1, ops[i].size, ops[i].addr};
				msect <= ops[i].sect;
				@(posedge clk_sys);
				mem <= '0;
			end
			wait_idle();
			check("op status", seen, {24'h0, ops[i].exp});
			check("op irq", 32'(irq), 32'(ops[i].exp[1:0] != 2'h0));
			if (ops[i].exp[0] && ops[i].ctrl[CR_SECT]) check("sector", 32'(last_sector), 32'(ops[i].ctrl[6:3]));
			if (ops[i].exp[0]) chk_rd("start clear", OFF_OPERATION_CONTROL, ops[i].ctrl & ~32'h00010000);
			wr(OFF_OPERATION_STATUS, 32'h000000f3);
			chk_rd("status clear", OFF_OPERATION_STATUS, 32'h0);
			check("irq clear", 32'(irq), 32'h0);
		end
		$display("test operations done");
		wr(OFF_OPTION_CONTROL, 32'h0fffaa02);
		chk_rd("locked opt", OFF_OPTION_CONTROL, 32'h0ff5cc6d);
		wr(OFF_OPTION_UNLOCK_KEY, FIRST_OPTION_KEY);
		wr(OFF_OPTION_UNLOCK_KEY, SECOND_OPTION_KEY);
		chk_rd("unlocked opt", OFF_OPTION_CONTROL, 32'h0ff5cc6c);
		wr(OFF_OPTION_CONTROL, 32'h0fffaa02);
		wait_idle();
		chk_rd("opt done", OFF_OPTION_CONTROL, 32'h0fffaa00);
		check("stored opt", stored & OPT_FIELD_MASK, 32'h0fffaa00);
		check("protect level0", 32'(prot_lvl), 32'h0);
		check("bor on", 32'(boroff), 32'h0);
		// every sector is unprotected now, so a mass erase must run to completion
		wr(OFF_OPERATION_CONTROL, 32'h01010004);
		wait_idle();
		check("mass erase", seen, 32'h1);
		check("mass erase irq", 32'(irq), 32'h1);
		wr(OFF_OPERATION_STATUS, 32'h000000f3);
		wr(OFF_OPTION_CONTROL, 32'h0fffaa01);
		chk_rd("opt relock", OFF_OPTION_CONTROL, 32'h0fffaa01);
		wr(OFF_OPERATION_CONTROL, CONTROL_RESET);
		chk_rd("ctrl relock", OFF_OPERATION_CONTROL, CONTROL_RESET);
		$display("test option update done");
		// a wrong or out-of-order key blocks unlocking until reset
		wr(OFF_PROGRAM_UNLOCK_KEY, 32'h12345678);
		wr(OFF_PROGRAM_UNLOCK_KEY, FIRST_UNLOCK_KEY);
		wr(OFF_PROGRAM_UNLOCK_KEY, SECOND_UNLOCK_KEY);
		chk_rd("stuck ctrl", OFF_OPERATION_CONTROL, CONTROL_RESET);
		wr(OFF_OPTION_UNLOCK_KEY, SECOND_OPTION_KEY);
		wr(OFF_OPTION_UNLOCK_KEY, FIRST_OPTION_KEY);
		wr(OFF_OPTION_UNLOCK_KEY, SECOND_OPTION_KEY);
		chk_rd("stuck opt", OFF_OPTION_CONTROL, 32'h0fffaa01);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		release_reset();
		chk_rd("reloaded opt", OFF_OPTION_CONTROL, 32'h0fffaa01);
		wr(OFF_PROGRAM_UNLOCK_KEY, FIRST_UNLOCK_KEY);
		wr(OFF_PROGRAM_UNLOCK_KEY, SECOND_UNLOCK_KEY);
		chk_rd("unlock after reset", OFF_OPERATION_CONTROL, 32'h0);
		$display("test failed unlock done");
		complete_run();
	end
endmodule

// [unlock_tracker.sv]
// key-pair detector with refusal until reset after a wrong key
module unlock_tracker
	import flash_pe_pkg::*;
#(
	parameter logic [31:0] FIRST_KEY  = 32'h0,
	parameter logic [31:0] SECOND_KEY = 32'h0
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// key writes
	input  wire logic        key_wr_in,
	input  wire logic [31:0] key_in,
	// lock request from software, lock state
	input  wire logic        relock_in,
	output logic             locked_out
);

	typedef struct packed {
		logic got_first;
		logic blocked;
		logic locked;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// a wrong key write between the two keys breaks the pair
	// refusal until reset
	always_comb begin
		state_next = state_reg;
		if (key_wr_in && !state_reg.blocked && state_reg.locked) begin
			if (!state_reg.got_first && key_in == FIRST_KEY) begin
				state_next.got_first = 1'b1;
			end else if (state_reg.got_first && key_in == SECOND_KEY) begin
				state_next.got_first = 1'b0;
				state_next.locked    = 1'b0;
			end else begin
				state_next.got_first = 1'b0;
				state_next.blocked   = 1'b1;
			end
		end else if (key_wr_in) begin
			state_next.got_first = 1'b0;
			if (!state_reg.locked) begin
				state_next.blocked = 1'b1;
				state_next.locked  = 1'b1;
			end
		end
		if (relock_in) begin
			state_next.locked    = 1'b1;
			state_next.got_first = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= '{got_first: 1'b0, blocked: 1'b0, locked: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign locked_out = state_reg.locked;

endmodule
